/* rtl/status_regs_pkg.sv */
// Package: offsets, field positions and reset values of the status slice
package status_regs_pkg;
  localparam logic [7:0] ADDR_BUS_SWITCH_CONTROL = 8'h1E;
  localparam logic [7:0] ADDR_USER_ARRAY_LOCK = 8'h20;
  localparam logic [7:0] ADDR_DEVICE_CONDITION_FLAGS = 8'h21;
  localparam logic [7:0] ADDR_DEVICE_FAULT_FLAGS = 8'h22;
  localparam logic [7:0] ADDR_ENABLE_A_CONTROL = 8'h23;
  localparam int SWITCH_DRIVE_BIT = 0;
  localparam int LOCK_BIT = 7;
  localparam int COND_RESET_BIT = 6;
  localparam int COND_OSC_BIT = 5;
  localparam int COND_SWITCH_BIT = 4;
  localparam int COND_TEST_BIT = 3;
  localparam int COND_ST_RUN_BIT = 2;
  localparam int COND_OFFSET_BIT = 1;
  localparam int COND_OC_DONE_BIT = 0;
  localparam int FAULT_FACTORY_BIT = 7;
  localparam int FAULT_USER_NV_BIT = 6;
  localparam int FAULT_RW_BIT = 5;
  localparam int FAULT_UNLOCKED_BIT = 4;
  localparam int FAULT_ST_PEND_BIT = 2;
  localparam int FAULT_BUF_LOW_BIT = 1;
  localparam int FAULT_BUS_LOW_BIT = 0;
  localparam int ST_PATTERN_HIGH_BIT = 1;
  localparam int ST_PATTERN_LOW_BIT = 2;
  localparam int ST_ENABLE_BIT = 0;
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] ENABLE_A_RESET = 8'h00;
  localparam logic [3:0] PHYS_ADDR_RESET = 4'h0;
endpackage : status_regs_pkg

/* rtl/bus_switch_lock_status_regs.sv */
// Bus switch, user array lock and device status register slice
// What this block does
// R1: Switch bit drives pin low when set
// R2: Switch register joins read/write integrity check
// R3: Condition bit 4 mirrors switch pin activity
// R4: Lock refuses user array writes, starts verify
// R5: Lock burned only if set at program
// R6: Physical address mirror stays writable after lock
// R7: Both status registers ignore master writes
// R8: Reset flag set by reset, read clears
// R9: Oscillator fault set on training/timing error
// R10: Test flag follows test mode
// R11: Enable_a running equals OR of control bits
// R12: Offset fault set at offset limit
// R13: Offset cancel done after init finishes
// R14: Factory array fault cleared only by reset
// R15: User array fault cleared only by reset
// R16: Read/write array fault cleared only by reset
// R17: Unlocked flag is inverse of lock
// R18: Enable_a pending cleared by enable write
// R19: Buffer supply low set, read clears
// R20: Bus input low set, read clears
// R21: Periodic mode entry clears enable_a control
// R22: Set beats simultaneous clearing read
module bus_switch_lock_status_regs
  import status_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_refused,
  input wire logic user_array_wr,
  input wire logic [3:0] phys_addr_wdata,
  input wire logic program_nv,
  input wire logic osc_training_fault,
  input wire logic factory_test_flag,
  input wire logic offset_limit_hit,
  input wire logic offset_cancel_done,
  input wire logic factory_array_fault,
  input wire logic user_array_fault,
  input wire logic rw_array_fault,
  input wire logic buffer_supply_low,
  input wire logic bus_input_low,
  input wire logic periodic_collection_mode,
  output logic bus_switch_pin_o,
  output logic bus_switch_pin_oe,
  output logic user_array_write_ok,
  output logic user_array_verify_en,
  output logic rw_array_verify_include_switch,
  output logic [3:0] phys_addr_mirror,
  output logic [7:0] enable_a_control,
  output logic lock_burned
);
  // Lanes of the two-stage synchroniser for asynchronous status inputs
  localparam int SYNC_W = 7;
  localparam int SYNC_PERIODIC_COLLECTION_MODE = 0;
  localparam int SYNC_BUS_LOW = 1;
  localparam int SYNC_BUF_LOW = 2;
  localparam int SYNC_OC_DONE = 3;
  localparam int SYNC_OFFSET = 4;
  localparam int SYNC_TEST = 5;
  localparam int SYNC_OSC = 6;
  localparam int ST_W = 3;

  typedef struct packed {
    logic [7:0] rdata;
    logic refused;
    logic switch_drive;
    logic lock_mirror;
    logic lock_nv;
    logic [3:0] phys_addr;
    logic [ST_W-1:0] st_ctrl;
    logic reset_flag;
    logic osc_flag;
    logic offset_flag;
    logic factory_fault;
    logic user_fault;
    logic rw_fault;
    logic st_pending;
    logic buf_low;
    logic bus_low;
    logic periodic_collection_mode_d;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [SYNC_W-1:0] async_in;
  logic [7:0] cond_view;
  logic [7:0] fault_view;
  logic [7:0] read_view;
  logic rd_switch;
  logic rd_lock;
  logic rd_cond;
  logic rd_fault;
  logic rd_enable_a;
  logic wr_switch;
  logic wr_lock;
  logic wr_enable_a;
  logic wr_status;
  logic lock_refused;
  logic user_refused;
  logic periodic_collection_mode_entry;
  logic osc_seen;
  logic offset_seen;
  logic test_level;
  logic oc_done_level;
  logic buf_low_seen;
  logic bus_low_seen;
  logic wdata_switch;
  logic wdata_lock;
  logic wdata_enable;
  logic [ST_W-1:0] wdata_st;

  // Only the second stage of the synchroniser is read by logic
  assign async_in[SYNC_PERIODIC_COLLECTION_MODE] = periodic_collection_mode;
  assign async_in[SYNC_BUS_LOW] = bus_input_low;
  assign async_in[SYNC_BUF_LOW] = buffer_supply_low;
  assign async_in[SYNC_OC_DONE] = offset_cancel_done;
  assign async_in[SYNC_OFFSET] = offset_limit_hit;
  assign async_in[SYNC_TEST] = factory_test_flag;
  assign async_in[SYNC_OSC] = osc_training_fault;

  assign osc_seen = state_reg.sync2[SYNC_OSC];
  assign offset_seen = state_reg.sync2[SYNC_OFFSET];
  assign test_level = state_reg.sync2[SYNC_TEST];
  assign oc_done_level = state_reg.sync2[SYNC_OC_DONE];
  assign buf_low_seen = state_reg.sync2[SYNC_BUF_LOW];
  assign bus_low_seen = state_reg.sync2[SYNC_BUS_LOW];
  assign periodic_collection_mode_entry = state_reg.sync2[SYNC_PERIODIC_COLLECTION_MODE] && !state_reg.periodic_collection_mode_d;

  assign rd_switch = reg_rd && (reg_addr == ADDR_BUS_SWITCH_CONTROL);
  assign rd_lock = reg_rd && (reg_addr == ADDR_USER_ARRAY_LOCK);
  assign rd_cond = reg_rd && (reg_addr == ADDR_DEVICE_CONDITION_FLAGS);
  assign rd_fault = reg_rd && (reg_addr == ADDR_DEVICE_FAULT_FLAGS);
  assign rd_enable_a = reg_rd && (reg_addr == ADDR_ENABLE_A_CONTROL);
  assign wr_switch = reg_wr && (reg_addr == ADDR_BUS_SWITCH_CONTROL);
  assign wr_lock = reg_wr && (reg_addr == ADDR_USER_ARRAY_LOCK);
  assign wr_enable_a = reg_wr && (reg_addr == ADDR_ENABLE_A_CONTROL);
  assign wr_status = reg_wr && ((reg_addr == ADDR_DEVICE_CONDITION_FLAGS)
                     || (reg_addr == ADDR_DEVICE_FAULT_FLAGS)); // R7

  assign wdata_switch = reg_wdata[SWITCH_DRIVE_BIT];
  assign wdata_lock = reg_wdata[LOCK_BIT];
  assign wdata_enable = reg_wdata[ST_ENABLE_BIT];
  assign wdata_st = reg_wdata[ST_W-1:0];

  // Lock burned: lock and user array writes are refused
  assign lock_refused = wr_lock && state_reg.lock_nv; // R4
  assign user_refused = user_array_wr && state_reg.lock_nv; // R4

  always_comb begin
    cond_view = 8'h00;
    cond_view[COND_RESET_BIT] = state_reg.reset_flag;
    cond_view[COND_OSC_BIT] = state_reg.osc_flag;
    cond_view[COND_SWITCH_BIT] = state_reg.switch_drive; // R3
    cond_view[COND_TEST_BIT] = test_level; // R10
    cond_view[COND_ST_RUN_BIT] = |state_reg.st_ctrl; // R11
    cond_view[COND_OFFSET_BIT] = state_reg.offset_flag;
    cond_view[COND_OC_DONE_BIT] = oc_done_level; // R13
    fault_view = 8'h00;
    fault_view[FAULT_FACTORY_BIT] = state_reg.factory_fault;
    fault_view[FAULT_USER_NV_BIT] = state_reg.user_fault;
    fault_view[FAULT_RW_BIT] = state_reg.rw_fault;
    fault_view[FAULT_UNLOCKED_BIT] = ~state_reg.lock_nv; // R17
    fault_view[FAULT_ST_PEND_BIT] = state_reg.st_pending;
    fault_view[FAULT_BUF_LOW_BIT] = state_reg.buf_low;
    fault_view[FAULT_BUS_LOW_BIT] = state_reg.bus_low;
  end

  // Unmapped reads return zero
  always_comb begin
    if (rd_switch) begin
      read_view = {7'h00, state_reg.switch_drive};
    end else if (rd_lock) begin
      read_view = {state_reg.lock_mirror, 7'h00};
    end else if (rd_cond) begin
      read_view = cond_view;
    end else if (rd_fault) begin
      read_view = fault_view;
    end else if (rd_enable_a) begin
      read_view = {5'h00, state_reg.st_ctrl};
    end else begin
      read_view = 8'h00;
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.refused = 1'b0;
    state_next.sync1 = async_in;
    state_next.sync2 = state_reg.sync1;
    state_next.periodic_collection_mode_d = state_reg.sync2[SYNC_PERIODIC_COLLECTION_MODE];
    if (reg_rd) begin
      state_next.rdata = read_view;
    end
    // Clear on read first, so sets below win
    if (rd_cond) begin
      state_next.reset_flag = 1'b0; // R8
    end
    if (rd_fault) begin
      state_next.buf_low = 1'b0; // R19
      state_next.bus_low = 1'b0; // R20
    end
    if (wr_switch) begin
      state_next.switch_drive = wdata_switch; // R1
    end
    if (wr_lock && !state_reg.lock_nv) begin
      state_next.lock_mirror = wdata_lock; // R4
    end
    if (wr_enable_a) begin
      state_next.st_ctrl = wdata_st;
    end
    if (wr_enable_a && wdata_enable) begin
      state_next.st_pending = 1'b0; // R18
    end
    if (wr_status || lock_refused || user_refused) begin
      state_next.refused = 1'b1; // R4 R7
    end
    // Mirror of the physical address stays writable after lock
    if (user_array_wr) begin
      state_next.phys_addr = phys_addr_wdata; // R6
    end
    if (program_nv && state_reg.lock_mirror) begin
      state_next.lock_nv = 1'b1; // R5
    end
    // Entry into periodic mode beats a same-cycle control write
    if (periodic_collection_mode_entry) begin
      state_next.st_ctrl = '0; // R21
    end
    // Sticky sets, winning over clears
    if (osc_seen) begin
      state_next.osc_flag = 1'b1; // R9
    end
    if (offset_seen) begin
      state_next.offset_flag = 1'b1; // R12
    end
    if (factory_array_fault) begin
      state_next.factory_fault = 1'b1; // R14
    end
    if (user_array_fault) begin
      state_next.user_fault = 1'b1; // R15
    end
    if (rw_array_fault) begin
      state_next.rw_fault = 1'b1; // R16
    end
    if (buf_low_seen) begin
      state_next.buf_low = 1'b1; // R19 R22
    end
    if (bus_low_seen) begin
      state_next.bus_low = 1'b1; // R20 R22
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.switch_drive <= SWITCH_RESET[SWITCH_DRIVE_BIT];
      state_reg.lock_mirror <= LOCK_RESET[LOCK_BIT];
      state_reg.phys_addr <= PHYS_ADDR_RESET;
      state_reg.st_ctrl <= ENABLE_A_RESET[ST_W-1:0];
      state_reg.reset_flag <= 1'b1; // R8
      state_reg.st_pending <= 1'b1; // R18
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign reg_refused = state_reg.refused;
  assign bus_switch_pin_o = 1'b0;
  assign bus_switch_pin_oe = state_reg.switch_drive; // R1
  assign user_array_write_ok = ~state_reg.lock_nv; // R4
  assign user_array_verify_en = state_reg.lock_nv; // R4
  assign rw_array_verify_include_switch = 1'b1; // R2
  assign phys_addr_mirror = state_reg.phys_addr;
  assign enable_a_control = {5'h00, state_reg.st_ctrl};
  assign lock_burned = state_reg.lock_nv;
endmodule : bus_switch_lock_status_regs

/* verification/status_regs_sva.sv */
// Checker of the status slice port behaviour
module status_regs_sva
  import status_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_refused,
  input wire logic program_nv,
  input wire logic periodic_collection_mode,
  input wire logic bus_switch_pin_oe,
  input wire logic user_array_write_ok,
  input wire logic user_array_verify_en,
  input wire logic [7:0] enable_a_control,
  input wire logic lock_burned
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_switch_drive: assert property (
    reg_wr && reg_addr == 8'h1E |=> bus_switch_pin_oe == $past(reg_wdata[0]))
    else $error("switch drive wrong");
  a_status_refused: assert property (
    reg_wr && reg_addr inside {8'h21, 8'h22} |=> reg_refused)
    else $error("status write not refused");
  a_switch_status: assert property (
    reg_rd && reg_addr == 8'h21 |=> reg_rdata[4] == $past(bus_switch_pin_oe))
    else $error("switch status wrong");
  a_enable_a_active: assert property (
    reg_rd && reg_addr == 8'h21 |=>
    reg_rdata[2] == |($past(enable_a_control) & 8'h07))
    else $error("enable_a running wrong");
  a_lock_verify: assert property (
    user_array_verify_en == lock_burned && user_array_write_ok != lock_burned)
    else $error("lock outputs wrong");
  a_lock_cause: assert property (
    $rose(lock_burned) |-> $past(program_nv))
    else $error("lock burned without program");
  a_unlock_flag: assert property (
    reg_rd && reg_addr == 8'h22 |=> reg_rdata[4] == !$past(lock_burned))
    else $error("unlocked flag wrong");
  a_periodic_clear: assert property (
    $rose(periodic_collection_mode) |-> ##[1:4] enable_a_control == 8'h00)
    else $error("enable_a control not cleared");
  cover property (reg_refused);
  cover property ($rose(lock_burned));
  cover property (reg_rd && reg_addr == 8'h22);
endmodule : status_regs_sva
bind bus_switch_lock_status_regs status_regs_sva u_sva (.clk, .rst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_refused, .program_nv,
  .periodic_collection_mode, .bus_switch_pin_oe, .user_array_write_ok,
  .user_array_verify_en, .enable_a_control, .lock_burned);

/* verification/bus_master.sv */
// Register bus master model for the status slice
module bus_master (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic program_nv,
  output logic user_array_wr,
  output logic [3:0] phys_addr_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, program_nv, user_array_wr} = 4'h0;
  initial {reg_addr, reg_wdata, phys_addr_wdata} = 20'h0;
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk);
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    q = reg_rdata;
  endtask : xfer
  task automatic strobe(input logic p, input logic [3:0] pa);
    @(negedge clk);
    {program_nv, user_array_wr, phys_addr_wdata} = {p, !p, pa};
    @(negedge clk);
    {program_nv, user_array_wr} = 2'b00;
  endtask : strobe
endmodule : bus_master

/* verification/testbench.sv */
// Self-checking bench of the status slice
module testbench import status_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, osc_training_fault = 0, factory_test_flag = 0;
  logic offset_limit_hit = 0, offset_cancel_done = 0, factory_array_fault = 0;
  logic user_array_fault = 0, rw_array_fault = 0, buffer_supply_low = 0;
  logic bus_input_low = 0, periodic_collection_mode = 0;
  logic reg_wr, reg_rd, program_nv, user_array_wr, reg_refused, lock_burned;
  logic bus_switch_pin_oe, user_array_write_ok, user_array_verify_en;
  logic bus_switch_pin_o, rw_verify_sw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, enable_a_control;
  logic [3:0] phys_addr_wdata, phys_addr_mirror;
  int mismatches = 0, checked = 0;
  always #50 clk = ~clk;
  bus_master m (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .program_nv, .user_array_wr, .phys_addr_wdata);
  bus_switch_lock_status_regs dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_refused, .user_array_wr, .phys_addr_wdata,
    .program_nv, .osc_training_fault, .factory_test_flag, .offset_limit_hit,
    .offset_cancel_done, .factory_array_fault, .user_array_fault,
    .rw_array_fault, .buffer_supply_low, .bus_input_low,
    .periodic_collection_mode, .bus_switch_pin_o, .bus_switch_pin_oe,
    .user_array_write_ok, .user_array_verify_en,
    .rw_array_verify_include_switch(rw_verify_sw), .phys_addr_mirror,
    .enable_a_control,
    .lock_burned);
  task chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rdc(input logic [7:0] a, e);
    logic [7:0] q;
    m.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  task wr(input logic [7:0] a, d);
    logic [7:0] q;
    m.xfer(1'b1, a, d, q);
  endtask : wr
  task t_reset;
    rdc(8'h1E, 8'h00);
    chk({6'h0, bus_switch_pin_oe, user_array_write_ok}, 8'h01);
    rdc(8'h20, 8'h00);
    rdc(8'h22, 8'h14);
    rdc(8'h21, 8'h40);
    rdc(8'h21, 8'h00);
  endtask : t_reset
  task t_switch;
    wr(8'h1E, 8'h01);
    chk({6'h0, bus_switch_pin_oe, bus_switch_pin_o}, 8'h02);
    chk({7'h0, rw_verify_sw}, 8'h01);
    wr(8'h21, 8'hFF);
    chk({7'h0, reg_refused}, 8'h01);
    rdc(8'h21, 8'h10);
  endtask : t_switch
  task t_enable_a;
    wr(8'h23, 8'h01);
    chk(enable_a_control, 8'h01);
    rdc(8'h21, 8'h14);
    rdc(8'h22, 8'h10);
  endtask : t_enable_a
  task t_cond;
    {osc_training_fault, factory_test_flag} = 2'b11;
    {offset_limit_hit, offset_cancel_done} = 2'b11;
    repeat (5) @(negedge clk);
    rdc(8'h21, 8'h3F);
    {osc_training_fault, factory_test_flag, offset_limit_hit} = 3'b000;
    repeat (5) @(negedge clk);
    rdc(8'h21, 8'h37);
  endtask : t_cond
  task t_faults;
    {factory_array_fault, user_array_fault, rw_array_fault} = 3'b111;
    {buffer_supply_low, bus_input_low} = 2'b11;
    @(negedge clk);
    {factory_array_fault, user_array_fault, rw_array_fault} = 3'b000;
    repeat (5) @(negedge clk);
    rdc(8'h22, 8'hF3);
    rdc(8'h22, 8'hF3);
    {buffer_supply_low, bus_input_low} = 2'b00;
    repeat (5) @(negedge clk);
    rdc(8'h22, 8'hF3);
    rdc(8'h22, 8'hF0);
  endtask : t_faults
  task t_lock;
    periodic_collection_mode = 1'b1;
    repeat (5) @(negedge clk);
    chk(enable_a_control, 8'h00);
    wr(8'h20, 8'h80);
    rdc(8'h20, 8'h80);
    m.strobe(1'b1, 4'h0);
    chk({5'h0, user_array_write_ok, lock_burned, user_array_verify_en},
      8'h03);
    rdc(8'h22, 8'hE0);
    wr(8'h20, 8'h00);
    chk({7'h0, reg_refused}, 8'h01);
    m.strobe(1'b0, 4'h5);
    chk({4'h0, phys_addr_mirror}, 8'h05);
  endtask : t_lock
  task t_rerst;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rdc(8'h21, 8'h41);
    rdc(8'h22, 8'h14);
  endtask : t_rerst
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_switch;
    t_enable_a;
    t_cond;
    t_faults;
    t_lock;
    t_rerst;
    print_verdict;
  end
endmodule : testbench
